// file: rtl/sar_scan_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAR_SCAN_CFG_SVH
`define SAR_SCAN_CFG_SVH
`define OFF_MODE 12'h000
`define OFF_RUN 12'h004
`define OFF_SELECT 12'h008
`define OFF_IRQ_STATUS 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_BLOCK_CTRL 12'h014
`define OFF_RESULT_BASE 12'h040
`define OFF_RESULT_LAST 12'h07c
`define MODE_CONT_BIT 0
`define RUN_BIT 0
`define BLOCK_DISABLE_BIT 0
`define RESET_BLOCK_CTRL 1'b1
`define SAMPLE_TIME_NS 7300
`define CLOCK_PERIOD_NS 20
`define SAMPLE_CYCLES ((`SAMPLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define CONV_CYCLES 10
`endif

// file: rtl/sar_scan_pkg.sv
// Types shared by the scan sequencer
package sar_scan_pkg;
   typedef enum logic [1:0] {st_idle, st_sample, st_convert, st_next} seq_state_t;
   typedef struct packed {
      logic [9:0] value;
      logic [2:0] chan;
      logic valid;
   } conv_result_t;
endpackage : sar_scan_pkg

// file: rtl/sar_adc_scan_sequencer.sv
// Scan sequencer for an eight-channel SAR converter with APB registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "sar_scan_cfg.svh"

// What this block does
// - Converts only channels selected in the mask, storing into their own result.
// - Results of unselected channels stay untouched during a scan.
// - Run with empty mask keeps run at zero and converts nothing.
// - Writing run bit 0 to one starts scanning from the lowest channel.
// - Each result lands in that channel's low and high result pair.
// - Completion interrupt after the highest selected channel converts.
// - Single mode clears run after the last selected channel.
// - Continuous mode restarts from lowest channel while run stays set.
// - Mask captured at scan start, used until the completion interrupt.
// - Ten-bit result; low register holds bits 1:0 in bits 7:6.
// - High register holds result bits 9:2 in bits 7:0.
module sar_adc_scan_sequencer
   import sar_scan_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
   parameter int CONV_CYCLES = `CONV_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] conv_data,
   output logic conv_start,
   output logic [2:0] conv_chan,
   output logic conv_done_irq,
   output logic converter_block_disable
);
   // ==========================================================
   // State
   typedef struct packed {
      seq_state_t state;
      logic continuous_scan_sel;
      logic conv_run;
      logic block_disable;
      logic [7:0] channel_select_reg;
      logic [7:0] scan_mask;
      logic [2:0] chan;
      logic [12:0] count;
      logic irq_status;
      logic irq_mask;
      logic irq;
      logic start;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0][9:0] result;
   } regs_t;
   regs_t r;
   regs_t next_r;
   logic [9:0] data_q1, data_q2;
   // Lowest set bit at or above a start index; 4'h8 when none
   function automatic logic [3:0] first_chan(input logic [7:0] m,
                                             input logic [3:0] from);
      logic [3:0] f;
      f = 4'h8;
      for (int i = 7; i >= 0; i--)
      begin
         if (m[i] && (4'(i) >= from))
         begin
            f = 4'(i);
         end
      end
      return f;
   endfunction : first_chan
   // Converter data comes from the analog side, resync before use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_q1 <= 10'h000;
         data_q2 <= 10'h000;
      end
      else
      begin
         data_q1 <= conv_data;
         data_q2 <= data_q1;
      end
   end

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      logic wr, rd, done_evt;
      logic [3:0] nxt;
      logic [11:0] ridx;
      // Writes land on the edge where pready is seen high
      wr = psel && penable && pwrite && r.ready;
      rd = psel && !penable;
      nxt = 4'h8;
      done_evt = 1'b0;
      ridx = 12'h000;
      next_r = r;
      next_r.ready = 1'b0;
      next_r.start = 1'b0;
      next_r.err = 1'b0;
      // Sequencer
      case (r.state)
         st_idle:
         begin
            next_r.count = 13'h0000;
         end
         st_sample:
         begin
            if (r.count >= 13'(SAMPLE_CYCLES - 1))
            begin
               next_r.count = 13'h0000;
               next_r.start = 1'b1;
               next_r.state = st_convert;
            end
            else
            begin
               next_r.count = r.count + 13'h0001;
            end
         end
         st_convert:
         begin
            if (r.count >= 13'(CONV_CYCLES - 1))
            begin
               next_r.result[r.chan] = data_q2;
               next_r.state = st_next;
            end
            else
            begin
               next_r.count = r.count + 13'h0001;
            end
         end
         default:
         begin
            next_r.count = 13'h0000;
            nxt = first_chan(r.scan_mask, {1'b0, r.chan} + 4'h1);
            if (nxt != 4'h8)
            begin
               next_r.chan = nxt[2:0];
               next_r.state = st_sample;
            end
            else
            begin
               done_evt = 1'b1;
               if (r.continuous_scan_sel)
               begin
                  next_r.scan_mask = r.channel_select_reg;
                  nxt = first_chan(r.channel_select_reg, 4'h0);
                  if (nxt == 4'h8)
                  begin
                     next_r.conv_run = 1'b0;
                     next_r.state = st_idle;
                  end
                  else
                  begin
                     next_r.chan = nxt[2:0];
                     next_r.state = st_sample;
                  end
               end
               else
               begin
                  next_r.conv_run = 1'b0;
                  next_r.state = st_idle;
               end
            end
         end
      endcase
      // Software stop aborts the scan at once; a conversion ending in the same cycle still stores its result
      if (wr && paddr == `OFF_RUN && !pwdata[`RUN_BIT])
      begin
         next_r.conv_run = 1'b0;
         next_r.state = st_idle;
      end
      if (wr && paddr == `OFF_RUN && pwdata[`RUN_BIT] && !r.conv_run)
      begin
         if (r.channel_select_reg != 8'h00 && !r.block_disable)
         begin
            next_r.scan_mask = r.channel_select_reg;
            nxt = first_chan(r.channel_select_reg, 4'h0);
            next_r.chan = nxt[2:0];
            next_r.conv_run = 1'b1;
            next_r.count = 13'h0000;
            next_r.state = st_sample;
         end
      end
      // Register writes
      if (wr)
      begin
         if (paddr == `OFF_MODE)
         begin
            next_r.continuous_scan_sel = pwdata[`MODE_CONT_BIT];
         end
         else if (paddr == `OFF_SELECT)
         begin
            next_r.channel_select_reg = pwdata[7:0];
         end
         else if (paddr == `OFF_IRQ_MASK)
         begin
            next_r.irq_mask = pwdata[0];
         end
         else if (paddr == `OFF_BLOCK_CTRL)
         begin
            next_r.block_disable = pwdata[`BLOCK_DISABLE_BIT];
            if (pwdata[`BLOCK_DISABLE_BIT])
            begin
               next_r.conv_run = 1'b0;
               next_r.state = st_idle;
            end
         end
         else if (paddr == `OFF_IRQ_STATUS && pwdata[0])
         begin
            next_r.irq_status = 1'b0;
         end
      end
      // Set beats clear in the same cycle
      if (done_evt)
      begin
         next_r.irq_status = 1'b1;
      end
      next_r.irq = next_r.irq_status && next_r.irq_mask;
      // No stray start pulse once a stop or disable has won
      next_r.start = next_r.start && (next_r.state == st_convert);
      // Read data during setup, answer with pready after one wait state, in the second access cycle
      if (rd)
      begin
         next_r.rdata = 32'h0000_0000;
         next_r.err = 1'b0;
         ridx = paddr - `OFF_RESULT_BASE;
         if (paddr == `OFF_MODE)
         begin
            next_r.rdata[0] = r.continuous_scan_sel;
         end
         else if (paddr == `OFF_RUN)
         begin
            next_r.rdata[0] = r.conv_run;
         end
         else if (paddr == `OFF_SELECT)
         begin
            next_r.rdata[7:0] = r.channel_select_reg;
         end
         else if (paddr == `OFF_IRQ_STATUS)
         begin
            next_r.rdata[0] = r.irq_status;
         end
         else if (paddr == `OFF_IRQ_MASK)
         begin
            next_r.rdata[0] = r.irq_mask;
         end
         else if (paddr == `OFF_BLOCK_CTRL)
         begin
            next_r.rdata[0] = r.block_disable;
         end
         else if (paddr >= `OFF_RESULT_BASE && paddr <= `OFF_RESULT_LAST
                  && paddr[1:0] == 2'b00)
         begin
            if (ridx[2])
            begin
               next_r.rdata[7:0] = r.result[ridx[5:3]][9:2];
            end
            else
            begin
               next_r.rdata[7:6] = r.result[ridx[5:3]][1:0];
            end
         end
         else
         begin
            next_r.err = 1'b1;
         end
      end
      if (psel && penable && !r.ready)
      begin
         next_r.ready = 1'b1;
         next_r.err = r.err && !pwrite; // Reads only
      end
   end
   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.block_disable <= `RESET_BLOCK_CTRL;
      end
      else
      begin
         r <= next_r;
      end
   end
   // Outputs straight from flip-flops
   assign prdata = r.rdata;
   assign pready = r.ready;
   assign pslverr = r.err;
   assign conv_start = r.start;
   assign conv_chan = r.chan;
   assign conv_done_irq = r.irq;
   assign converter_block_disable = r.block_disable;
   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   empty_run_held_a: assert property (r.state == st_idle && psel
      && penable && pwrite && paddr == `OFF_RUN && pwdata[0]
      && r.channel_select_reg == 8'h00 && !r.conv_run |=> !r.conv_run)
      else $error("run set with empty mask");
   single_run_clear_a: assert property (r.state == st_next
      && !r.continuous_scan_sel && first_chan(r.scan_mask,
      {1'b0, r.chan} + 4'h1) == 4'h8 |=> !r.conv_run)
      else $error("single scan left run set");
   done_irq_status_a: assert property (r.state == st_next
      && first_chan(r.scan_mask, {1'b0, r.chan} + 4'h1) == 4'h8
      |=> r.irq_status)
      else $error("completion not flagged");
   chan_selected_a: assert property (r.state == st_convert
      |-> r.scan_mask[r.chan])
      else $error("unselected channel converted");
   mask_held_a: assert property (r.state == st_convert
      |=> $stable(r.scan_mask))
      else $error("mask changed mid scan");
   result_unsel_a: assert property (r.conv_run && !r.scan_mask[0]
      && r.state != st_idle |=> $stable(r.result[0]))
      else $error("unselected result changed");
   ascend_a: assert property (r.state == st_next
      && $past(r.state) == st_convert ##1 r.state == st_sample
      |-> r.chan > $past(r.chan, 1) || r.continuous_scan_sel)
      else $error("channel order wrong");
   start_pulse_a: assert property (r.start
      |-> r.state == st_convert ##1 !r.start)
      else $error("start not single pulse");
   irq_level_a: assert property (r.irq_status && r.irq_mask
      |-> conv_done_irq) else $error("irq not raised");
   single_scan_c: cover property (r.conv_run ##1 !r.conv_run && r.irq_status);
   cont_scan_c: cover property (r.continuous_scan_sel && r.state == st_next
      ##1 r.state == st_sample && r.chan <= $past(r.chan));
   empty_start_c: cover property (psel && penable && pwrite
      && paddr == `OFF_RUN && r.channel_select_reg == 8'h00);
endmodule : sar_adc_scan_sequencer
`default_nettype wire

// file: sim/sar_analog_front_model.sv
// Behavioural model of the analog converter behind the sequencer
`timescale 1ns/1ns
`default_nettype none
module sar_analog_front_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] conv_chan,
   input wire logic [9:0] base,
   output logic [9:0] conv_data
);
   // =====
   // Held sample
   // pin tracks source
   // Value depends on channel so a misrouted store is visible
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_data <= 10'h3ff;
      else
         conv_data <= base ^ {conv_chan, 7'h15};
   end
endmodule : sar_analog_front_model
`default_nettype wire

// file: sim/sar_adc_scan_sequencer_bench.sv
// Self-checking bench for the scan sequencer over APB
`timescale 1ns/1ns
`default_nettype none
`include "sar_scan_cfg.svh"
module sar_adc_scan_sequencer_bench;
   import sar_scan_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [9:0] base = 10'h0a5;
   logic [31:0] prdata, rd;
   logic pready, pslverr, conv_start, conv_done_irq, converter_block_disable;
   logic err;
   logic [9:0] conv_data, b1;
   logic [2:0] conv_chan;
   logic [2:0] order [$];
   int miscompares = 0;
   int tests_run = 0;
   int starts = 0;
   int n;
   // =====
   // Clock, design and far side
   always #10 pclk = ~pclk;
   sar_adc_scan_sequencer #(.CHANNELS(8), .SAMPLE_CYCLES(3), .CONV_CYCLES(2))
   i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_data(conv_data),
      .conv_start(conv_start), .conv_chan(conv_chan),
      .conv_done_irq(conv_done_irq),
      .converter_block_disable(converter_block_disable));
   sar_analog_front_model i_front (.pclk(pclk), .presetn(presetn),
      .conv_chan(conv_chan), .base(base), .conv_data(conv_data));
   // Log every conversion start and its channel
   always @(posedge pclk)
   begin
      if (conv_start === 1'b1)
      begin
         starts++;
         order.push_back(conv_chan);
      end
   end
   // =====
   // Tasks
   // One APB transfer; waits on pready, never on a fixed count
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
         miscompares++;
   endtask : apb
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_check
   // Low word keeps two bits at the top of the byte, high word the rest
   task automatic res_check(input int c, input logic [9:0] v);
      rd_check(`OFF_RESULT_BASE + 12'(8 * c), {24'h0, v[1:0], 6'h00});
      rd_check(`OFF_RESULT_BASE + 12'(8 * c + 4), {24'h0, v[9:2]});
   endtask : res_check
   // Bounded wait until the conversion start count reaches the target
   task automatic wait_starts(input int target);
      for (int k = 0; k < 400 && starts < target; k++)
         @(posedge pclk);
   endtask : wait_starts
   task automatic close_out;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   // =====
   // Watchdog, far above the expected run length
   initial
   begin
      #200000;
      miscompares++;
      close_out();
   end
   // =====
   // Tests
   initial
   begin
      // clock runs settled from time zero, before any access
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd_check(`OFF_MODE, 32'h0);
      rd_check(`OFF_RUN, 32'h0);
      rd_check(`OFF_SELECT, 32'h0);
      for (int c = 0; c < 8; c++) res_check(c, 10'h000);
      rd_check(`OFF_BLOCK_CTRL, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      check({rd[31:1], err}, 32'h1);
      $display("test reset and map done");
      // Empty mask must not start anything
      apb(1'b1, `OFF_BLOCK_CTRL, 32'h0);
      @(posedge pclk);
      check({31'h0, converter_block_disable}, 32'h0);
      apb(1'b1, `OFF_RUN, 32'h1);
      repeat (20) @(posedge pclk);
      rd_check(`OFF_RUN, 32'h0);
      check(32'(starts), 32'h0);
      $display("test empty mask done");
      // Single scan of 0, 2, 7 with a mask rewrite in flight
      apb(1'b1, `OFF_IRQ_MASK, 32'h1);
      apb(1'b1, `OFF_SELECT, 32'h85);
      apb(1'b1, `OFF_MODE, 32'h0);
      apb(1'b1, `OFF_RUN, 32'h1);
      apb(1'b1, `OFF_SELECT, 32'h02);
      wait_starts(3);
      for (n = 0; n < 100 && conv_done_irq !== 1'b1; n++) @(posedge pclk);
      check({31'h0, conv_done_irq}, 32'h1);
      check(32'(order.size()), 32'h3);
      check({order[0], order[1], order[2]}, {3'd0, 3'd2, 3'd7});
      rd_check(`OFF_RUN, 32'h0);
      rd_check(`OFF_IRQ_STATUS, 32'h1);
      b1 = base;
      res_check(0, b1 ^ 10'h015);
      res_check(2, b1 ^ 10'h115);
      res_check(7, b1 ^ 10'h395);
      res_check(1, 10'h000);
      apb(1'b1, `OFF_IRQ_STATUS, 32'h1);
      @(posedge pclk);
      check({31'h0, conv_done_irq}, 32'h0);
      $display("test single scan done");
      // Continuous scan of 0 and 1, interrupt masked, stopped by software
      base <= 10'h3c6;
      apb(1'b1, `OFF_IRQ_MASK, 32'h0);
      apb(1'b1, `OFF_SELECT, 32'h03);
      apb(1'b1, `OFF_MODE, 32'h1);
      apb(1'b1, `OFF_RUN, 32'h1);
      wait_starts(8);
      check({order[3], order[4], order[5], order[6]}, 12'o0101);
      rd_check(`OFF_RUN, 32'h1);
      rd_check(`OFF_IRQ_STATUS, 32'h1);
      check({31'h0, conv_done_irq}, 32'h0);
      apb(1'b1, `OFF_RUN, 32'h0);
      @(posedge pclk);
      n = starts;
      repeat (30) @(posedge pclk);
      check(32'(starts - n), 32'h0);
      res_check(1, 10'h3c6 ^ 10'h095);
      res_check(2, b1 ^ 10'h115);
      $display("test continuous scan done");
      // Disabled block must refuse a run even with channels selected
      apb(1'b1, `OFF_BLOCK_CTRL, 32'h1);
      apb(1'b1, `OFF_RUN, 32'h1);
      repeat (20) @(posedge pclk);
      rd_check(`OFF_RUN, 32'h0);
      check(32'(starts - n), 32'h0);
      $display("test block disable done");
      close_out();
   end
endmodule : sar_adc_scan_sequencer_bench
`default_nettype wire
